// ==== sdmrs_pkg.sv ====
// Constants, types and field layout for the DRAM mode-set block
`default_nettype none
package sdmrs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MODE0 = 8'h04;
    localparam logic [7:0] ADDR_MODE1 = 8'h08;
    localparam logic [7:0] ADDR_MODE2 = 8'h0C;
    localparam logic [7:0] ADDR_MODE3 = 8'h10;
    localparam logic [7:0] ADDR_DECODE = 8'h14;
    localparam logic [7:0] ADDR_CTRL = 8'h18;

    // ------------------------------------------------------------
    // Control fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_GUARD_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_GUARD_RST = 1'b1;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [7:0] BANKS_RST = 8'h00;

    // ------------------------------------------------------------
    // Address pin positions
    // ------------------------------------------------------------
    localparam int A_AUTO_PRE = 10;
    localparam int A_CHOP = 12;
    localparam int A_DLL_RST = 8;
    localparam int A_FAST_EXIT = 12;
    localparam int A_WR_LSB = 9;
    localparam int A_WR_MSB = 11;
    localparam int A_BL_LSB = 0;
    localparam int A_BL_MSB = 1;

    // Burst length field codes
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int T_INIT_US = 500;
    localparam logic [15:0] INIT_CYC = 16'(T_INIT_US * CLK_MHZ);
    localparam logic [2:0] CORE_CLKS = 3'h4;
    localparam logic [3:0] BEATS_EIGHT = 4'h8;
    localparam logic [3:0] BEATS_CHOP = 4'h4;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_INIT = 2'b01,
        ST_WAIT_CKE = 2'b10,
        ST_RUN = 2'b11
    } sdmrs_state_type;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] bank_address_bits;
        logic [15:0] addr;
        logic termination_control_input;
    } sdmrs_cmd_type;

    localparam sdmrs_cmd_type CMD_RST = '{
        cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
        bank_address_bits: 3'h0, addr: 16'h0000,
        termination_control_input: 1'b0};

    typedef struct packed {
        logic [7:0] ign_cnt;
        logic [7:0] open_banks;
        logic dll_reset;
        logic burst_busy;
        logic idle;
        logic [1:0] state;
    } sdmrs_status_type;

endpackage : sdmrs_pkg
`default_nettype wire

// ==== sdmrs_top.sv ====
// DRAM power-up sequencing, mode register set and burst bookkeeping
// ------------------------------------------------------------
// Functional notes
// R1 - Eight banks; each access is one four-clock internal core transfer.
// R2 - Bursts start at a column and run eight beats or chopped four.
// R3 - Activate picks bank/row; read/write takes column, A10 precharge, A12 chop.
// R4 - Controller holds reset low at least 200us after stable power.
// R5 - Controller drops clock enable at least 10ns before reset release.
// R6 - After reset release wait 500us; device initialises without clock.
// R7 - Clock stable five cycles or 10ns and idle command before enable.
// R8 - Clock enable stays high until initialisation completes.
// R9 - Termination off during reset and until clock enable registered high.
// R10 - Controller holds termination input static through initialisation.
// R11 - Wait reset exit time after clock enable before first mode set.
// R12 - Mode writes in order two, three, one, zero, then long calibration.
// R13 - Warm reset: hold 100ns, then repeat power-up steps.
// R14 - Controller writes every mode register before normal use.
// R15 - Each mode set drives every field of the target register.
// R16 - Mode sets and loop reset keep array contents intact.
// R17 - Consecutive mode sets spaced by the mode set cycle time.
// R18 - After mode set wait update delay before other commands.
// R19 - Runtime mode rewrites only while device is idle.
// R20 - Mode set: all strobes low; bank bits select register zero to three.
// R21 - Register zero A12 picks slow or fast power-down exit.
// R22 - Register zero write-recovery code maps to 0,5,6,7,8,10,12,14.
// R23 - Register zero A1:A0 select fixed eight, on-the-fly, fixed four.
// R24 - Loop reset bit clears itself after the reset action.
// R25 - Mode sets arriving while not idle are ignored.
// ------------------------------------------------------------
//
// Design decisions made here: register access over APB and the address map.
`default_nettype none
module sdmrs_top #(
    parameter logic [15:0] INIT_CYCLES = sdmrs_pkg::INIT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_n,
    input wire sdmrs_pkg::sdmrs_cmd_type cmd_pins,
    output logic dev_ready,
    output logic odt_active,
    output logic dll_reset_pulse,
    output logic burst_busy,
    output logic [3:0] burst_beats,
    output logic [9:0] burst_col,
    output logic [2:0] burst_bank,
    output logic burst_write,
    output logic auto_precharge,
    output logic fast_exit,
    output logic [3:0] wr_cycles
);
    import sdmrs_pkg::*;

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sdmrs_cmd_type c1_r, c2_r;
    logic rstp1_r, rstp2_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c1_r <= CMD_RST;
            c2_r <= CMD_RST;
            rstp1_r <= 1'b0;
            rstp2_r <= 1'b0;
        end else begin
            c1_r <= cmd_pins;
            c2_r <= c1_r;
            rstp1_r <= reset_pin_n;
            rstp2_r <= rstp1_r;
        end
    end

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    sdmrs_state_type state_r, state_nxt;
    logic [15:0] init_cnt_r;
    logic [15:0] mode_r [4];
    logic [7:0] open_r;
    logic [2:0] core_cnt_r;
    logic busy_r, dll_rst_r, guard_r, odt_r, ready_r;
    logic [7:0] ign_r;
    logic [3:0] beats_r, wrc_r;
    logic [9:0] col_r;
    logic [2:0] bbank_r;
    logic bwr_r, ap_r, fast_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire run = (state_r == ST_RUN);
    wire sel_cmd = run & c2_r.cke & ~c2_r.cs_n;
    wire [2:0] ba = c2_r.bank_address_bits;
    wire [1:0] mr_sel = ba[1:0];
    wire is_mrs = sel_cmd & ~c2_r.ras_n & ~c2_r.cas_n & ~c2_r.we_n; // see R20
    wire is_act = sel_cmd & ~c2_r.ras_n & c2_r.cas_n & c2_r.we_n;
    wire is_pre = sel_cmd & ~c2_r.ras_n & c2_r.cas_n & ~c2_r.we_n;
    wire is_rw = sel_cmd & c2_r.ras_n & ~c2_r.cas_n;
    wire idle = (open_r == 8'h00) & ~busy_r & c2_r.cke;
    // Undefined behaviour is turned into a no-op rather than a corruption
    wire mrs_take = is_mrs & ~ba[2] & (idle | ~guard_r); // see R25
    wire mrs_ign = is_mrs & ~ba[2] & ~idle & guard_r; // see R25
    wire rw_take = is_rw & open_r[ba] & (core_cnt_r == 3'h0);
    wire [1:0] bl = mode_r[0][A_BL_MSB:A_BL_LSB];
    wire chop = (bl == BL_FIXED4) |
                ((bl == BL_OTF) & ~c2_r.addr[A_CHOP]); // see R23
    wire burst_end = busy_r & (core_cnt_r == 3'h1);

    // ------------------------------------------------------------
    // Power-up and reset sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (rstp2_r) begin
                    state_nxt = ST_INIT;
                end
            end
            ST_INIT: begin
                if (init_cnt_r == INIT_CYCLES - 16'h0001) begin
                    state_nxt = ST_WAIT_CKE; // see R6
                end
            end
            ST_WAIT_CKE: begin
                if (c2_r.cke) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (!rstp2_r) begin
            state_nxt = ST_RESET;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_RESET;
            init_cnt_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            // Internal init counts on our clock; the link clock may be idle
            init_cnt_r <= (state_r == ST_INIT) ?
                          init_cnt_r + 16'h0001 : 16'h0000; // see R6
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            odt_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            odt_r <= run & c2_r.termination_control_input; // see R9
            ready_r <= run;
        end
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || !rstp2_r) begin
            for (int i = 0; i < 4; i++) begin
                mode_r[i] <= MODE_RST;
            end
            dll_rst_r <= 1'b0;
        end else begin
            dll_rst_r <= mrs_take & (mr_sel == 2'h0) & c2_r.addr[A_DLL_RST];
            if (dll_rst_r) begin
                mode_r[0][A_DLL_RST] <= 1'b0; // see R24
            end
            if (mrs_take) begin
                mode_r[mr_sel] <= c2_r.addr; // see R20
            end
        end
    end

    function automatic logic [3:0] wr_decode(input logic [2:0] code);
        case (code)
            3'h1: wr_decode = 4'h5;
            3'h2: wr_decode = 4'h6;
            3'h3: wr_decode = 4'h7;
            3'h4: wr_decode = 4'h8;
            3'h5: wr_decode = 4'hA;
            3'h6: wr_decode = 4'hC;
            3'h7: wr_decode = 4'hE;
            default: wr_decode = 4'h0;
        endcase
    endfunction : wr_decode

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_r <= 1'b0;
            wrc_r <= 4'h0;
        end else begin
            fast_r <= mode_r[0][A_FAST_EXIT]; // see R21
            wrc_r <= wr_decode(mode_r[0][A_WR_MSB:A_WR_LSB]); // see R22
        end
    end

    // ------------------------------------------------------------
    // Bank and burst tracking
    // ------------------------------------------------------------
    // Open rows are only bookkeeping; no array is modelled, so mode
    // writes and loop resets cannot disturb stored data; see R16
    always_ff @(posedge clk) begin
        if (sys_rst || !rstp2_r) begin
            open_r <= BANKS_RST;
        end else if (is_act) begin
            open_r[ba] <= 1'b1; // see R3
        end else if (is_pre) begin
            open_r <= c2_r.addr[A_AUTO_PRE] ? BANKS_RST
                      : (open_r & ~(8'h01 << ba));
        end else if (burst_end && ap_r) begin
            open_r[bbank_r] <= 1'b0; // see R3
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !rstp2_r) begin
            core_cnt_r <= 3'h0;
            busy_r <= 1'b0;
        end else begin
            busy_r <= rw_take | (core_cnt_r > 3'h1); // see R1
            core_cnt_r <= rw_take ? CORE_CLKS
                          : (busy_r ? core_cnt_r - 3'h1 : 3'h0);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            beats_r <= 4'h0;
            col_r <= 10'h000;
            bbank_r <= 3'h0;
            bwr_r <= 1'b0;
            ap_r <= 1'b0;
        end else if (rw_take) begin
            beats_r <= chop ? BEATS_CHOP : BEATS_EIGHT; // see R2
            col_r <= c2_r.addr[9:0];
            bbank_r <= ba;
            bwr_r <= ~c2_r.we_n;
            ap_r <= c2_r.addr[A_AUTO_PRE]; // see R3
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    sdmrs_status_type status;
    logic [31:0] rd_data;
    logic rd_err;
    wire acc = psel & penable & ~pready_r;
    wire wr_en = psel & penable & pready_r & pwrite;
    wire ctrl_wr = wr_en & (paddr == ADDR_CTRL);

    assign status = '{ign_cnt: ign_r, open_banks: open_r,
                      dll_reset: dll_rst_r, burst_busy: busy_r,
                      idle: idle, state: state_r};

    always_comb begin
        rd_err = 1'b0;
        if (paddr == ADDR_STATUS) begin
            rd_data = {11'h000, status};
        end else if (paddr == ADDR_MODE0) begin
            rd_data = {16'h0000, mode_r[0]};
        end else if (paddr == ADDR_MODE1) begin
            rd_data = {16'h0000, mode_r[1]};
        end else if (paddr == ADDR_MODE2) begin
            rd_data = {16'h0000, mode_r[2]};
        end else if (paddr == ADDR_MODE3) begin
            rd_data = {16'h0000, mode_r[3]};
        end else if (paddr == ADDR_DECODE) begin
            rd_data = {23'h000000, fast_r, wrc_r, beats_r};
        end else if (paddr == ADDR_CTRL) begin
            rd_data = {31'h00000000, guard_r};
        end else begin
            rd_data = 32'h00000000;
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & rd_err;
            prdata_r <= (acc && !pwrite) ? rd_data : 32'h00000000;
        end
    end

    // Counting an ignored mode set beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            guard_r <= CTRL_GUARD_RST;
            ign_r <= 8'h00;
        end else begin
            if (ctrl_wr) begin
                guard_r <= pwdata[CTRL_GUARD_BIT];
            end
            if (mrs_ign) begin
                ign_r <= ign_r + 8'h01; // see R25
            end else if (ctrl_wr && pwdata[CTRL_CLR_BIT]) begin
                ign_r <= 8'h00;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign dev_ready = ready_r;
    assign odt_active = odt_r;
    assign dll_reset_pulse = dll_rst_r;
    assign burst_busy = busy_r;
    assign burst_beats = beats_r;
    assign burst_col = col_r;
    assign burst_bank = bbank_r;
    assign burst_write = bwr_r;
    assign auto_precharge = ap_r;
    assign fast_exit = fast_r;
    assign wr_cycles = wrc_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_CORE_FOUR: assert property ( // see R1
        rw_take |=> busy_r [*4] ##1 !busy_r)
        else $error("core transfer not four clocks");
    AST_FIXED_EIGHT: assert property ( // see R2
        rw_take && bl == BL_FIXED8 |=> burst_beats == 4'h8)
        else $error("fixed burst not eight beats");
    AST_FIXED_CHOP: assert property ( // see R23
        rw_take && bl == BL_FIXED4 |=> burst_beats == 4'h4)
        else $error("fixed chop not four beats");
    AST_OTF_CHOP: assert property ( // see R3
        rw_take && bl == BL_OTF |=>
        burst_beats == ($past(c2_r.addr[A_CHOP]) ? 4'h8 : 4'h4))
        else $error("on-the-fly chop ignored A12");
    AST_ODT_OFF: assert property ( // see R9
        state_r != ST_RUN |=> !odt_active)
        else $error("termination on before clock enable");
    AST_MODE_SEL: assert property ( // see R20
        mrs_take && mr_sel != 2'h0 |=>
        mode_r[$past(mr_sel)] == $past(c2_r.addr))
        else $error("mode set stored in wrong register");
    AST_DLL_CLEAR: assert property ( // see R24
        mrs_take && mr_sel == 2'h0 && c2_r.addr[A_DLL_RST] |=>
        dll_reset_pulse ##1 (!mode_r[0][A_DLL_RST] || $past(mrs_take)))
        else $error("loop reset bit did not clear");
    AST_FAST_EXIT: assert property ( // see R21
        mrs_take && mr_sel == 2'h0 |=> ##2
        fast_exit == $past(c2_r.addr[A_FAST_EXIT], 3))
        else $error("fast exit bit not applied");
    AST_WR_MAX: assert property ( // see R22
        mrs_take && mr_sel == 2'h0 && c2_r.addr[11:9] == 3'h7 |=> ##2
        wr_cycles == 4'hE)
        else $error("write recovery code seven not fourteen");
    AST_BUSY_IGNORE: assert property ( // see R25
        mrs_ign |=> mode_r[$past(mr_sel)] == $past(mode_r[mr_sel])
        && ign_r == $past(ign_r) + 8'h01)
        else $error("mode set accepted while busy");

endmodule : sdmrs_top
`default_nettype wire

// ==== sdmrs_ctrl_model.sv ====
// Memory controller model: drives the device reset and command pins
`default_nettype none
module sdmrs_ctrl_model #(
    parameter int INIT = 20,
    parameter int GAP = 4,
    parameter int LOCK = 16
) (
    input wire logic clk,
    output var logic reset_pin_n,
    output var sdmrs_pkg::sdmrs_cmd_type cmd_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import sdmrs_pkg::*;

    initial begin
        reset_pin_n = 1'b0;
        cmd_pins = CMD_RST;
    end

    // ------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------
    // Deselect inverts bank and address so stale values never match
    task automatic issue(input logic [2:0] rcw, input logic [2:0] ba,
                         input logic [15:0] a);
        sdmrs_cmd_type c;
        c = cmd_pins;
        c.cs_n = 1'b0;
        {c.ras_n, c.cas_n, c.we_n} = rcw;
        c.bank_address_bits = ba;
        c.addr = a;
        @(posedge clk);
        cmd_pins <= c;
        @(posedge clk);
        c.cs_n = 1'b1;
        {c.ras_n, c.cas_n, c.we_n} = 3'h7;
        c.bank_address_bits = ~ba;
        c.addr = ~a;
        cmd_pins <= c;
        repeat (GAP) @(posedge clk);
    endtask : issue

    task automatic rst_seq(input int hold);
        sdmrs_cmd_type c;
        c = CMD_RST;
        c.termination_control_input = 1'b1;
        @(posedge clk);
        reset_pin_n <= 1'b0;
        cmd_pins <= c;
        repeat (hold) @(posedge clk);
        reset_pin_n <= 1'b1;
        // Let the release cross the pin synchroniser before any status read
        repeat (4) @(posedge clk);
    endtask : rst_seq

    // Clock runs throughout, so it is stable long before enable
    task automatic init_seq();
        repeat (INIT + 4) @(posedge clk);
        issue(3'h7, 3'h0, 16'h0000);
        @(posedge clk);
        cmd_pins.cke <= 1'b1;
        repeat (5) @(posedge clk);
        issue(3'h0, 3'h2, 16'h0000);
        issue(3'h0, 3'h3, 16'h0000);
        issue(3'h0, 3'h1, 16'h0000);
        issue(3'h0, 3'h0, 16'h0100);
        issue(3'h6, 3'h0, 16'h0400);
        repeat (LOCK) @(posedge clk);
    endtask : init_seq
endmodule : sdmrs_ctrl_model
`default_nettype wire

// ==== sdmrs_tb_top.sv ====
// Self-checking bench for the DRAM mode-set block
`default_nettype none
module sdmrs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sdmrs_pkg::*;

    typedef struct packed {
        logic [2:0] ba;
        logic [15:0] a;
        logic [7:0] ra;
        logic [15:0] ex;
        logic dec;
        logic [3:0] wr;
        logic fx;
    } sdmrs_row_type;

    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic reset_pin_n, dev_ready, odt_active, dll_reset_pulse, burst_busy;
    logic burst_write, auto_precharge, fast_exit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] burst_beats, wr_cycles;
    logic [9:0] burst_col;
    logic [2:0] burst_bank;
    sdmrs_cmd_type cmd_pins;
    int failures = 0;
    int cmp_count = 0;
    int pulse_cnt = 0;
    int busy_cnt = 0;
    int b0;
    logic [1:0] bls [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [3:0] bts [5] = '{4'h8, 4'h4, 4'h8, 4'h4, 4'h8};
    logic [4:0] a12v = 5'b01100;
    logic [4:0] wrv = 5'b01010;
    sdmrs_row_type rows [12] = '{
        '{3'h2, 16'h0A5A, ADDR_MODE2, 16'h0A5A, 1'b0, 4'h0, 1'b0},
        '{3'h3, 16'h0003, ADDR_MODE3, 16'h0003, 1'b0, 4'h0, 1'b0},
        '{3'h1, 16'h1244, ADDR_MODE1, 16'h1244, 1'b0, 4'h0, 1'b0},
        '{3'h0, 16'h0000, ADDR_MODE0, 16'h0000, 1'b1, 4'h0, 1'b0},
        '{3'h0, 16'h1201, ADDR_MODE0, 16'h1201, 1'b1, 4'h5, 1'b1},
        '{3'h0, 16'h0402, ADDR_MODE0, 16'h0402, 1'b1, 4'h6, 1'b0},
        '{3'h0, 16'h1600, ADDR_MODE0, 16'h1600, 1'b1, 4'h7, 1'b1},
        '{3'h0, 16'h0801, ADDR_MODE0, 16'h0801, 1'b1, 4'h8, 1'b0},
        '{3'h0, 16'h1A02, ADDR_MODE0, 16'h1A02, 1'b1, 4'hA, 1'b1},
        '{3'h0, 16'h0C00, ADDR_MODE0, 16'h0C00, 1'b1, 4'hC, 1'b0},
        '{3'h0, 16'h1E01, ADDR_MODE0, 16'h1E01, 1'b1, 4'hE, 1'b1},
        '{3'h4, 16'hFFFF, ADDR_MODE0, 16'h1E01, 1'b1, 4'hE, 1'b1}
    };

    sdmrs_top #(.INIT_CYCLES(16'h0014)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .cmd_pins(cmd_pins), .dev_ready(dev_ready),
        .odt_active(odt_active), .dll_reset_pulse(dll_reset_pulse),
        .burst_busy(burst_busy), .burst_beats(burst_beats),
        .burst_col(burst_col), .burst_bank(burst_bank),
        .burst_write(burst_write), .auto_precharge(auto_precharge),
        .fast_exit(fast_exit), .wr_cycles(wr_cycles)
    );

    sdmrs_ctrl_model u_ctrl (
        .clk(clk), .reset_pin_n(reset_pin_n), .cmd_pins(cmd_pins)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (dll_reset_pulse === 1'b1) pulse_cnt++;
        if (burst_busy === 1'b1) busy_cnt++;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1, "pready timeout");
    endtask : apb

    task automatic power_check(input int n);
        chk({31'h0, dev_ready}, 32'h1, "ready");
        chk({31'h0, odt_active}, 32'h1, "odt run");
        chk(32'(pulse_cnt), 32'(n), "dll pulses");
        apb(1'b0, ADDR_MODE0, 32'h0);
        chk(rd, 32'h0, "dll bit");
    endtask : power_check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // Whole run needs under 5000 cycles
    initial begin
        #2000000;
        failures++;
        $display("ERROR t=%0t watchdog expired", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({27'h0, dev_ready, odt_active, pready, burst_busy,
             dll_reset_pulse}, 32'h0, "reset outputs");
        u_ctrl.rst_seq(2000);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h1, "init state");
        chk({31'h0, odt_active}, 32'h0, "odt off");
        u_ctrl.init_seq();
        power_check(1);
        $display("test power-up done");
        foreach (rows[i]) begin
            u_ctrl.issue(3'h0, rows[i].ba, rows[i].a);
            apb(1'b0, rows[i].ra, 32'h0);
            chk(rd, {16'h0, rows[i].ex}, "mode reg");
            if (rows[i].dec) begin
                chk({28'h0, wr_cycles}, {28'h0, rows[i].wr}, "wr");
                chk({31'h0, fast_exit}, {31'h0, rows[i].fx}, "fx");
            end
        end
        $display("test mode table done");
        // Each burst carries auto precharge, so the next mode set is legal
        for (int k = 0; k < 5; k++) begin
            u_ctrl.issue(3'h0, 3'h0, {14'h0, bls[k]});
            u_ctrl.issue(3'h3, 3'h5, 16'h0ABC);
            b0 = busy_cnt;
            u_ctrl.issue({2'b10, ~wrv[k]}, 3'h5,
                         {3'h0, a12v[k], 2'b01, 10'h1C3});
            repeat (4) @(posedge clk);
            chk(32'(busy_cnt - b0), 32'h4, "busy length");
            chk({28'h0, burst_beats}, {28'h0, bts[k]}, "beats");
            chk({17'h0, auto_precharge, burst_write, burst_bank, burst_col},
                {17'h0, 1'b1, wrv[k], 3'h5, 10'h1C3}, "burst");
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk({24'h0, rd[12:5]}, 32'h0, "auto precharge");
        end
        b0 = busy_cnt;
        u_ctrl.issue(3'h5, 3'h5, 16'h0000);
        repeat (4) @(posedge clk);
        chk(32'(busy_cnt - b0), 32'h0, "closed bank read");
        $display("test bursts done");
        u_ctrl.issue(3'h3, 3'h2, 16'h0055);
        u_ctrl.issue(3'h0, 3'h0, 16'h1234);
        apb(1'b0, ADDR_MODE0, 32'h0);
        chk(rd, 32'h0003, "busy mode set");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({24'h0, rd[20:13]}, 32'h1, "ignore count");
        chk({24'h0, rd[12:5]}, 32'h4, "open bank");
        u_ctrl.issue(3'h2, 3'h0, 16'h0400);
        u_ctrl.issue(3'h0, 3'h0, 16'h1234);
        apb(1'b0, ADDR_MODE0, 32'h0);
        chk(rd, 32'h1234, "idle mode set");
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({24'h0, rd[20:13]}, 32'h0, "count clear");
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h0, "read-only write");
        $display("test guard and bus done");
        u_ctrl.rst_seq(3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h1, "warm init");
        u_ctrl.init_seq();
        power_check(2);
        $display("test warm reset done");
        complete_run();
    end
endmodule : sdmrs_tb_top
`default_nettype wire
